// >>> rtl/vrad_dec_if.sv
// Link between the sequencer and the port decoder
`timescale 1ns/1ps
`default_nettype none
interface vrad_dec_if;
    import vrad_pkg::*;
    logic [11:0] byte_addr;
    logic color_emul;
    vrad_sel_t sel;
    modport dec (input byte_addr, input color_emul, output sel);
    modport usr (output byte_addr, output color_emul, input sel);
endinterface
`default_nettype wire

// >>> rtl/vrad_decode.sv
// Legacy VGA port decoder for one byte offset
`timescale 1ns/1ps
`default_nettype none
module vrad_decode
    import vrad_pkg::*;
(
    // Decode link
    vrad_dec_if.dec dif
);
    // Status 1 and feature write follow the mono/colour emulation
    wire logic [11:0] input_status_second_addr = dif.color_emul ? VRAD_INPUT_STATUS_SECOND_COLOR : VRAD_INPUT_STATUS_SECOND_MONO;

    // Only original VGA ports are claimed
    always_comb begin
        case (dif.byte_addr)
            VRAD_ST00_MISCW: dif.sel = VRAD_SEL_ST00_MISCW;
            VRAD_FCR_RD: dif.sel = VRAD_SEL_FCR_RD;
            VRAD_MISC_RD: dif.sel = VRAD_SEL_MISC_RD;
            VRAD_PAL_RIDX: dif.sel = VRAD_SEL_PAL_RIDX;
            VRAD_PAL_WIDX: dif.sel = VRAD_SEL_PAL_WIDX;
            VRAD_PAL_DATA: dif.sel = VRAD_SEL_PAL_DATA;
            VRAD_GFX_IDX: dif.sel = VRAD_SEL_GFX_IDX;
            VRAD_GFX_DATA: dif.sel = VRAD_SEL_GFX_DATA;
            default: dif.sel = (dif.byte_addr == input_status_second_addr) ? VRAD_SEL_INPUT_STATUS_SECOND_FCRW : VRAD_SEL_NONE;
        endcase
    end
endmodule
`default_nettype wire

// >>> rtl/vrad_pkg.sv
// Constants and types shared by the VGA register access decoder
package vrad_pkg;
    // Register space extent
    localparam logic [31:0] VRAD_SPACE_LAST = 32'h0000_0FFF;
    // Legacy port offsets
    localparam logic [11:0] VRAD_ST00_MISCW = 12'h3C2;
    localparam logic [11:0] VRAD_PAL_RIDX = 12'h3C7;
    localparam logic [11:0] VRAD_PAL_WIDX = 12'h3C8;
    localparam logic [11:0] VRAD_PAL_DATA = 12'h3C9;
    localparam logic [11:0] VRAD_FCR_RD = 12'h3CA;
    localparam logic [11:0] VRAD_MISC_RD = 12'h3CC;
    localparam logic [11:0] VRAD_GFX_IDX = 12'h3CE;
    localparam logic [11:0] VRAD_GFX_DATA = 12'h3CF;
    localparam logic [11:0] VRAD_INPUT_STATUS_SECOND_MONO = 12'h3BA;
    localparam logic [11:0] VRAD_INPUT_STATUS_SECOND_COLOR = 12'h3DA;
    // Graphics controller indexes of note
    localparam logic [4:0] VRAD_GFX_MODE_IDX = 5'h05;
    localparam logic [4:0] VRAD_GFX_MISC_IDX = 5'h06;
    localparam logic [4:0] VRAD_GFX_LAST_STD = 5'h08;
    localparam logic [4:0] VRAD_EXT_A_IDX = 5'h10;
    localparam logic [4:0] VRAD_EXT_B_IDX = 5'h11;
    // Field positions
    localparam int VRAD_MISC_COLOR_BIT = 0;
    localparam int VRAD_MISC_RAMEN_BIT = 1;
    localparam int VRAD_FCR_VSC_BIT = 3;
    localparam int VRAD_MEMMAP_LSB = 2;
    localparam int VRAD_INPUT_STATUS_SECOND_DE_BIT = 0;
    localparam int VRAD_INPUT_STATUS_SECOND_VS_BIT = 3;
    // Reset and fixed values
    localparam logic [7:0] VRAD_REG_RST = 8'h00;
    localparam logic [7:0] VRAD_ST00_VAL = 8'h10;
    localparam logic [31:0] VRAD_BAD_READ = 32'hFFFF_FFFF;
    localparam logic [1:0] VRAD_DAC_RD_MODE = 2'h3;
    localparam logic [1:0] VRAD_COMP_LAST = 2'h2;

    // Transaction sizes
    typedef enum logic [1:0] {
        VRAD_SZ_BYTE = 2'b00,
        VRAD_SZ_WORD = 2'b01,
        VRAD_SZ_DWORD = 2'b10
    } vrad_size_t;

    // Decoded port selection
    typedef enum logic [3:0] {
        VRAD_SEL_NONE = 4'b0000,
        VRAD_SEL_ST00_MISCW = 4'b0001,
        VRAD_SEL_INPUT_STATUS_SECOND_FCRW = 4'b0010,
        VRAD_SEL_FCR_RD = 4'b0011,
        VRAD_SEL_MISC_RD = 4'b0100,
        VRAD_SEL_PAL_RIDX = 4'b0101,
        VRAD_SEL_PAL_WIDX = 4'b0110,
        VRAD_SEL_PAL_DATA = 4'b0111,
        VRAD_SEL_GFX_IDX = 4'b1000,
        VRAD_SEL_GFX_DATA = 4'b1001
    } vrad_sel_t;

    // Transaction sequencer states
    typedef enum logic [1:0] {
        VRAD_ST_IDLE = 2'b00,
        VRAD_ST_LO = 2'b01,
        VRAD_ST_HI = 2'b10
    } vrad_state_t;
endpackage

// >>> rtl/vrad_top.sv
// VGA register access decoder: sequencer, legacy registers, palette
`timescale 1ns/1ps
`default_nettype none
module vrad_top
    import vrad_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_is_io,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    // Host answer
    output logic rsp_valid,
    output logic rsp_hit,
    output logic [31:0] rsp_rdata,
    // Configuration and mode
    input wire logic [31:0] aperture_base_register,
    input wire logic vga_mode_active,
    // Display pipe status pins
    input wire logic disp_en_in,
    input wire logic vsync_in,
    // Display side
    input wire logic [7:0] pal_lookup_idx,
    output logic [17:0] pal_lookup_q,
    output logic [7:0] disp_misc_q,
    output logic [7:0] disp_gfx_mode_q,
    output logic [1:0] mem_map_q,
    output logic ram_en_q,
    output logic [7:0] ext_gfx_ctl_reg_a,
    output logic [7:0] ext_gfx_ctl_reg_b
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    vrad_state_t state_q;
    logic ready_q, rsp_valid_q;
    logic [31:0] rdata_q;
    logic wr_q, io_q, bad_q, inrange_q, hit_q;
    vrad_size_t size_q;
    logic [11:0] off_q;
    logic [15:0] wdata_q;
    logic [7:0] misc_q, fcr_q;
    logic [4:0] gfx_idx_q;
    logic [7:0] gfx_q [0:31];
    logic [17:0] pal_mem [0:255];
    logic [7:0] pal_widx_q, pal_ridx_q;
    logic [1:0] pal_comp_q;
    logic pal_rd_mode_q;
    logic [11:0] pal_acc_q;
    logic de_meta_q, de_sync_q, vs_meta_q, vs_sync_q;
    logic [7:0] ext_a_q, ext_b_q;
    logic [7:0] rd_byte_c;

    vrad_dec_if dif ();

    // Valid register indexes, standard set plus the two extended ones
    function automatic logic gfx_idx_ok(input logic [4:0] idx);
        gfx_idx_ok = (idx <= VRAD_GFX_LAST_STD) || (idx == VRAD_EXT_A_IDX)
            || (idx == VRAD_EXT_B_IDX);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification
    wire logic take = req_valid && ready_q;
    wire logic [31:0] mem_off = req_addr - aperture_base_register;
    wire logic [31:0] req_off = req_is_io ? req_addr : mem_off;
    wire logic req_inrange = req_off <= VRAD_SPACE_LAST;
    wire logic req_bad = (req_size == VRAD_SZ_DWORD) || (req_size == 2'b11)
        || ((req_size == VRAD_SZ_WORD) && req_addr[0]);
    wire logic phase_hi = (state_q == VRAD_ST_HI);
    wire logic busy = (state_q == VRAD_ST_LO) || phase_hi;
    wire logic act = busy && inrange_q && !bad_q;
    wire logic wr_stb = act && wr_q && (dif.sel != VRAD_SEL_NONE);
    wire logic rd_stb = act && !wr_q && (dif.sel != VRAD_SEL_NONE);
    wire logic [7:0] wbyte = phase_hi ? wdata_q[15:8] : wdata_q[7:0];
    wire logic word_go = (size_q == VRAD_SZ_WORD) && !bad_q && !phase_hi;

    // Same decode serves I/O and aperture accesses
    assign dif.byte_addr = off_q + {11'h000, phase_hi};
    assign dif.color_emul = misc_q[VRAD_MISC_COLOR_BIT];

    vrad_decode u_dec (
        .dif(dif.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-port write and read strobes
    wire logic wr_misc = wr_stb && (dif.sel == VRAD_SEL_ST00_MISCW);
    wire logic wr_fcr = wr_stb && (dif.sel == VRAD_SEL_INPUT_STATUS_SECOND_FCRW);
    wire logic wr_gidx = wr_stb && (dif.sel == VRAD_SEL_GFX_IDX);
    wire logic wr_gdat = wr_stb && (dif.sel == VRAD_SEL_GFX_DATA) && gfx_idx_ok(gfx_idx_q);
    wire logic wr_pridx = wr_stb && (dif.sel == VRAD_SEL_PAL_RIDX);
    wire logic wr_pwidx = wr_stb && (dif.sel == VRAD_SEL_PAL_WIDX);
    wire logic wr_pdat = wr_stb && (dif.sel == VRAD_SEL_PAL_DATA);
    wire logic rd_pdat = rd_stb && (dif.sel == VRAD_SEL_PAL_DATA);
    wire logic comp_end = (pal_comp_q == VRAD_COMP_LAST);
    wire logic [17:0] pal_rd_word = pal_mem[pal_ridx_q];
    wire logic [5:0] pal_comp_val = (pal_comp_q == 2'h0) ? pal_rd_word[17:12]
        : (pal_comp_q == 2'h1) ? pal_rd_word[11:6] : pal_rd_word[5:0];
    wire logic [7:0] input_status_second_val = {4'h0, vs_sync_q, 2'b00, de_sync_q};
    wire logic [7:0] gfx_rd = gfx_idx_ok(gfx_idx_q) ? gfx_q[gfx_idx_q] : VRAD_REG_RST;

    // Read data mux for the current byte
    always_comb begin
        case (dif.sel)
            VRAD_SEL_ST00_MISCW: rd_byte_c = VRAD_ST00_VAL;
            VRAD_SEL_INPUT_STATUS_SECOND_FCRW: rd_byte_c = input_status_second_val;
            VRAD_SEL_FCR_RD: rd_byte_c = fcr_q;
            VRAD_SEL_MISC_RD: rd_byte_c = misc_q;
            VRAD_SEL_PAL_RIDX: rd_byte_c = {6'h00, pal_rd_mode_q ? VRAD_DAC_RD_MODE : 2'h0};
            VRAD_SEL_PAL_WIDX: rd_byte_c = pal_widx_q;
            VRAD_SEL_PAL_DATA: rd_byte_c = {2'b00, pal_comp_val};
            VRAD_SEL_GFX_IDX: rd_byte_c = {3'h0, gfx_idx_q};
            VRAD_SEL_GFX_DATA: rd_byte_c = gfx_rd;
            default: rd_byte_c = VRAD_REG_RST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer: take, low byte, optional high byte, answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= VRAD_ST_IDLE;
            ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                VRAD_ST_IDLE: if (take) begin
                    state_q <= VRAD_ST_LO;
                    ready_q <= 1'b0;
                end
                VRAD_ST_LO: if (word_go) begin
                    state_q <= VRAD_ST_HI;
                end else begin
                    state_q <= VRAD_ST_IDLE;
                    ready_q <= 1'b1;
                    rsp_valid_q <= 1'b1;
                end
                VRAD_ST_HI: begin
                    state_q <= VRAD_ST_IDLE;
                    ready_q <= 1'b1;
                    rsp_valid_q <= 1'b1;
                end
                default: state_q <= VRAD_ST_IDLE;
            endcase
        end
    end

    // Request capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {wr_q, io_q, bad_q, inrange_q} <= 4'h0;
            size_q <= VRAD_SZ_BYTE;
            off_q <= 12'h000;
            wdata_q <= 16'h0000;
        end else if (take) begin
            {wr_q, io_q, bad_q, inrange_q} <= {req_write, req_is_io, req_bad, req_inrange};
            size_q <= vrad_size_t'(req_size);
            off_q <= req_off[11:0];
            wdata_q <= req_wdata[15:0];
        end
    end

    // Answer data; unsupported in-range reads give all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end else if (state_q == VRAD_ST_LO) begin
            hit_q <= inrange_q && (dif.sel != VRAD_SEL_NONE);
            if (inrange_q && bad_q && !wr_q) rdata_q <= VRAD_BAD_READ;
            else rdata_q <= {24'h00_0000, rd_stb ? rd_byte_c : VRAD_REG_RST};
        end else if (phase_hi) begin
            rdata_q[15:8] <= rd_stb ? rd_byte_c : VRAD_REG_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General registers and graphics index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_q <= VRAD_REG_RST;
            fcr_q <= VRAD_REG_RST;
            gfx_idx_q <= 5'h00;
        end else begin
            if (wr_misc) misc_q <= wbyte;
            if (wr_fcr) fcr_q <= wbyte & (8'h01 << VRAD_FCR_VSC_BIT);
            if (wr_gidx) gfx_idx_q <= wbyte[4:0];
        end
    end

    // Graphics controller data array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) gfx_q[i] <= VRAD_REG_RST;
        end else if (wr_gdat) begin
            gfx_q[gfx_idx_q] <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Palette index, component and accumulator, live in every mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pal_widx_q <= 8'h00;
            pal_ridx_q <= 8'h00;
            pal_comp_q <= 2'h0;
            pal_rd_mode_q <= 1'b0;
            pal_acc_q <= 12'h000;
        end else if (wr_pwidx || wr_pridx) begin
            pal_widx_q <= wbyte;
            pal_ridx_q <= wbyte;
            pal_comp_q <= 2'h0;
            pal_rd_mode_q <= wr_pridx;
        end else if (wr_pdat || rd_pdat) begin
            pal_comp_q <= comp_end ? 2'h0 : pal_comp_q + 2'h1;
            if (wr_pdat) pal_acc_q <= {pal_acc_q[5:0], wbyte[5:0]};
            if (wr_pdat && comp_end) pal_widx_q <= pal_widx_q + 8'h01;
            if (rd_pdat && comp_end) pal_ridx_q <= pal_ridx_q + 8'h01;
        end
    end

    // Palette storage and display lookup
    always_ff @(posedge clk) begin
        if (wr_pdat && comp_end) pal_mem[pal_widx_q] <= {pal_acc_q, wbyte[5:0]};
        pal_lookup_q <= pal_mem[pal_lookup_idx];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status pins pass two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {de_meta_q, de_sync_q, vs_meta_q, vs_sync_q} <= 4'h0;
        end else begin
            {de_meta_q, vs_meta_q} <= {disp_en_in, vsync_in};
            {de_sync_q, vs_sync_q} <= {de_meta_q, vs_meta_q};
        end
    end

    // Display-side copies: mode-gated ones and always-live ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_misc_q <= VRAD_REG_RST;
            disp_gfx_mode_q <= VRAD_REG_RST;
            mem_map_q <= 2'b00;
            ram_en_q <= 1'b0;
            ext_a_q <= VRAD_REG_RST;
            ext_b_q <= VRAD_REG_RST;
        end else begin
            if (vga_mode_active) begin
                disp_misc_q <= misc_q;
                disp_gfx_mode_q <= gfx_q[VRAD_GFX_MODE_IDX];
            end
            mem_map_q <= gfx_q[VRAD_GFX_MISC_IDX][VRAD_MEMMAP_LSB+:2];
            ram_en_q <= misc_q[VRAD_MISC_RAMEN_BIT];
            ext_a_q <= gfx_q[VRAD_EXT_A_IDX];
            ext_b_q <= gfx_q[VRAD_EXT_B_IDX];
        end
    end

    // Port drives
    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_hit = hit_q;
    assign rsp_rdata = rdata_q;
    assign ext_gfx_ctl_reg_a = ext_a_q;
    assign ext_gfx_ctl_reg_b = ext_b_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_dword_write_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == VRAD_ST_LO && wr_q && bad_q) |=> (misc_q == $past(misc_q)
        && gfx_idx_q == $past(gfx_idx_q) && pal_widx_q == $past(pal_widx_q)))
        else $error("unsupported write changed a register");
    a_dword_read_ones: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == VRAD_ST_LO && !wr_q && bad_q && inrange_q) |=> rsp_valid_q
        && rsp_rdata[19:0] == 20'hFFFFF)
        else $error("unsupported read pattern wrong");
    a_word_two_bytes: assert property (@(posedge clk) disable iff (!rst_n)
        take && req_size == VRAD_SZ_WORD && !req_addr[0] |=> ##1 phase_hi ##1 rsp_valid_q)
        else $error("aligned word not done in two byte phases");
    a_odd_word_short: assert property (@(posedge clk) disable iff (!rst_n)
        take && req_size == VRAD_SZ_WORD && req_addr[0] |=> ##1 rsp_valid_q && !phase_hi)
        else $error("odd word not refused");
    a_range_no_hit: assert property (@(posedge clk) disable iff (!rst_n)
        take && !req_inrange |-> ##[2:3] rsp_valid_q && !hit_q)
        else $error("out of range access claimed");
    a_ext_gfx_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_gdat && gfx_idx_q == VRAD_EXT_A_IDX |=> ##1 ext_gfx_ctl_reg_a == $past(wbyte, 2))
        else $error("extended register write lost");
    a_disp_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !vga_mode_active |=> disp_misc_q == $past(disp_misc_q))
        else $error("display copy moved outside VGA mode");
    a_pal_any_mode: assert property (@(posedge clk) disable iff (!rst_n)
        wr_pdat && comp_end && !vga_mode_active |=> pal_widx_q == $past(pal_widx_q) + 8'h01)
        else $error("palette write stalled outside VGA mode");
    a_status_live: assert property (@(posedge clk) disable iff (!rst_n)
        rd_stb && !phase_hi && dif.sel == VRAD_SEL_INPUT_STATUS_SECOND_FCRW
        |=> rdata_q[VRAD_INPUT_STATUS_SECOND_DE_BIT] == $past(de_sync_q))
        else $error("status read lost display enable");
    a_memmap_live: assert property (@(posedge clk) disable iff (!rst_n)
        wr_gdat && gfx_idx_q == VRAD_GFX_MISC_IDX |=> ##1 mem_map_q == $past(wbyte[3:2], 2))
        else $error("segment control not applied");
    c_byte_write: cover property (@(posedge clk) disable iff (!rst_n)
        take && req_write && req_size == VRAD_SZ_BYTE);
    c_word_read: cover property (@(posedge clk) disable iff (!rst_n)
        phase_hi && !wr_q && rd_stb);
    c_dword_read: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid_q && bad_q && !wr_q);
    c_mem_hit: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid_q && hit_q && !io_q);
endmodule
`default_nettype wire

// >>> sim/vga_register_access_decode_tb.sv
// Self-checking bench for the VGA register access decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module vga_register_access_decode_tb
    import vrad_pkg::*;
;
    logic clk, rst_n, req_valid, req_ready, req_is_io, req_write, rsp_valid, rsp_hit;
    logic [1:0] req_size, mem_map_q;
    logic [31:0] req_addr, req_wdata, rsp_rdata, ap_base, rd;
    logic vga_on, de_pin, vs_pin, ram_en_q, h;
    logic [7:0] pal_idx, misc_q, gmode_q, ext_a, ext_b;
    logic [17:0] pal_q;
    int fail_count, n_tests, cyc;

    ////////////////////////////////////////////////////////////////////////
    // Design and host model
    vrad_top dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_is_io(req_is_io), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata), .aperture_base_register(ap_base),
        .vga_mode_active(vga_on), .disp_en_in(de_pin), .vsync_in(vs_pin),
        .pal_lookup_idx(pal_idx), .pal_lookup_q(pal_q), .disp_misc_q(misc_q),
        .disp_gfx_mode_q(gmode_q), .mem_map_q(mem_map_q), .ram_en_q(ram_en_q),
        .ext_gfx_ctl_reg_a(ext_a), .ext_gfx_ctl_reg_b(ext_b));
    vrad_host_model host_u (.clk(clk), .req_valid(req_valid), .req_ready(req_ready),
        .req_is_io(req_is_io), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared transfer with hit and data comparison
    task automatic acc(input logic io, input logic wr, input vrad_size_t sz,
                       input logic [31:0] a, input logic [31:0] wd,
                       input logic eh, input logic [31:0] er);
        host_u.access(io, wr, sz, a, wd, h, rd);
        `CHK($sformatf("hit at %h", a), eh, h)
        `CHK($sformatf("rdata at %h", a), er, rd)
    endtask

    // Direct ports, misc copy in VGA mode and colour emulation switch
    task automatic t_gen_ctl();
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3BA, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C2, 32'h01, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3CC, 32'h0, 1'b1, 32'h01);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C2, 32'h0, 1'b1, {24'h0, VRAD_ST00_VAL});
        `CHK("disp_misc_q", 8'h01, misc_q)
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3BA, 32'h0, 1'b0, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h300, 32'h0, 1'b0, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3DA, 32'hFF, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3CA, 32'h0, 1'b1, 32'h08);
    endtask

    // Word access to index/data pair reaching extended registers over I/O
    task automatic t_word_ext();
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CE, 32'h5A10, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_WORD, 32'h3CE, 32'h0, 1'b1, 32'h5A10);
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CE, 32'h3305, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CE, 32'hA511, 1'b1, 32'h0);
        // Display-side copies lag the register by one cycle
        @(negedge clk);
        `CHK("ext_a", 8'h5A, ext_a)
        `CHK("ext_b", 8'hA5, ext_b)
        `CHK("disp_gfx_mode_q", 8'h33, gmode_q)
    endtask

    // Dword and odd word requests refused
    task automatic t_refused();
        acc(1'b1, 1'b1, VRAD_SZ_DWORD, 32'h3C2, 32'hFF, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3CC, 32'h0, 1'b1, 32'h01);
        host_u.access(1'b1, 1'b0, VRAD_SZ_DWORD, 32'h3CC, 32'h0, h, rd);
        `CHK("dword read", 20'hFFFFF, rd[19:0])
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CF, 32'h7700, 1'b1, 32'h0);
        `CHK("ext_b kept", 8'hA5, ext_b)
        acc(1'b1, 1'b0, VRAD_SZ_WORD, 32'h3CF, 32'h0, 1'b1, VRAD_BAD_READ);
    endtask

    // Aperture aliasing and range limit
    task automatic t_mem_alias();
        acc(1'b0, 1'b1, VRAD_SZ_BYTE, ap_base + 32'h3C2, 32'h03, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3CC, 32'h0, 1'b1, 32'h03);
        acc(1'b0, 1'b0, VRAD_SZ_BYTE, ap_base + 32'h3CC, 32'h0, 1'b1, 32'h03);
        acc(1'b0, 1'b0, VRAD_SZ_BYTE, ap_base + 32'h13CC, 32'h0, 1'b0, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h13CC, 32'h0, 1'b0, 32'h0);
        `CHK("ram_en_q", 1'b1, ram_en_q)
    endtask

    // Functions kept alive outside VGA modes
    task automatic t_non_vga();
        @(negedge clk) vga_on = 1'b0;
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C2, 32'h01, 1'b1, 32'h0);
        @(negedge clk);
        `CHK("disp_misc_q held", 8'h03, misc_q)
        `CHK("ram_en_q live", 1'b0, ram_en_q)
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CE, 32'h0C06, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_WORD, 32'h3CE, 32'h4405, 1'b1, 32'h0);
        @(negedge clk);
        `CHK("mem_map_q", 2'h3, mem_map_q)
        `CHK("disp_gfx_mode_q held", 8'h33, gmode_q)
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C8, 32'h05, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C9, 32'h2A, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C9, 32'h15, 1'b1, 32'h0);
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C9, 32'h3F, 1'b1, 32'h0);
        @(negedge clk) pal_idx = 8'h05;
        @(negedge clk);
        `CHK("pal_lookup_q", {6'h2A, 6'h15, 6'h3F}, pal_q)
        acc(1'b1, 1'b1, VRAD_SZ_BYTE, 32'h3C7, 32'h05, 1'b1, 32'h0);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C9, 32'h0, 1'b1, 32'h2A);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C9, 32'h0, 1'b1, 32'h15);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C9, 32'h0, 1'b1, 32'h3F);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C7, 32'h0, 1'b1, 32'h03);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3C8, 32'h0, 1'b1, 32'h05);
        @(negedge clk) {de_pin, vs_pin} = 2'b11;
        repeat (4) @(negedge clk);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3DA, 32'h0, 1'b1, 32'h09);
        @(negedge clk) {de_pin, vs_pin} = 2'b00;
        repeat (4) @(negedge clk);
        acc(1'b1, 1'b0, VRAD_SZ_BYTE, 32'h3DA, 32'h0, 1'b1, 32'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        ap_base = 32'h0010_0000;
        vga_on = 1'b1; // Mode on with no other plane in use
        de_pin = 1'b0;
        vs_pin = 1'b0;
        pal_idx = 8'h00;
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_gen_ctl();
        t_word_ext();
        t_refused();
        t_mem_alias();
        t_non_vga();
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire

// >>> sim/vrad_host_model.sv
// Host bus master model issuing I/O and aperture transactions
`timescale 1ns/1ps
`default_nettype none
module vrad_host_model
    import vrad_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request
    output logic req_valid,
    input wire logic req_ready,
    output logic req_is_io,
    output logic req_write,
    output logic [1:0] req_size,
    output logic [31:0] req_addr,
    output logic [31:0] req_wdata,
    // Answer
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic [31:0] rsp_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req_is_io = 1'b1;
        req_write = 1'b0;
        req_size = 2'h0;
        req_addr = 32'h0;
        req_wdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer: held until taken, answer sampled in its pulse cycle
    task automatic access(input logic io, input logic wr, input vrad_size_t sz,
                          input logic [31:0] a, input logic [31:0] wd,
                          output logic hit, output logic [31:0] rd);
        int tries;
        tries = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_is_io = io;
        req_write = wr;
        req_size = sz;
        req_addr = a;
        req_wdata = wd;
        @(posedge clk);
        while (req_ready !== 1'b1 && tries < 20) begin
            tries++;
            @(posedge clk);
        end
        @(negedge clk);
        // Released lines show no stale value
        req_valid = 1'b0;
        req_addr = ~a;
        req_wdata = ~wd;
        while (rsp_valid !== 1'b1 && tries < 40) begin
            tries++;
            @(negedge clk);
        end
        hit = (tries < 40) ? rsp_hit : 1'bx;
        rd = rsp_rdata;
    endtask
endmodule
`default_nettype wire
